//--- include/dbi_bank_if.sv
/*
 * Carrier between the command decoder and one bank tracker.
 * Assumes one instance per bank, driven from the same clock.
 */
`default_nettype none

interface dbi_bank_if;
  logic doAct;   // Activate this bank.
  logic doRead;  // Start a read burst.
  logic doWrite; // Start a write burst.
  logic doPre;   // Precharge this bank.
  logic doBst;   // Terminate this bank's burst.
  logic autoPre; // The read or write carries autoprecharge.
  dbi_pkg::dbi_bank_state_t state; // Bank's current state.

  modport ctrl (output doAct, doRead, doWrite, doPre, doBst, autoPre,
                input state);
  modport bank (input doAct, doRead, doWrite, doPre, doBst, autoPre,
                output state);
endinterface

`default_nettype wire

//--- include/dbi_pkg.sv
/*
 * Shared constants, types and helpers for the bank interleave tracker.
 * Assumes a single 100 MHz clock and command pins already synchronous.
 */
// Function
// - Idle after precharge; active after activate time.
// - Read autoprecharge: access, then precharge at burst end.
// - Write autoprecharge: precharge begins after write recovery.
// - Other banks accept commands during autoprecharge.
// - Burst terminate hits the latest burst's bank.
// - Deselect and no operation continue previous operation.
// - Command encodings for activate, read, write, precharge, terminate.
`default_nettype none

package dbi_pkg;

  // Clock period in picoseconds at 100 MHz.
  localparam int CLK_PERIOD_PS = 10_000;

  // Bank timing in nanoseconds; plain defaults, the part decides.
  localparam int PRECHARGE_PERIOD_NS = 20;
  localparam int ACTIVATE_TO_ACCESS_NS = 20;
  localparam int WRITE_RECOVERY_NS = 15;
  localparam int WRITE_TO_READ_NS = 10;

  // Default burst length and read latency in half cycles.
  localparam int BURST_LENGTH_SETTING = 4;
  localparam int READ_LATENCY_X2 = 6;

  // Width of the per-bank down-counter and of the spacing counter.
  localparam int CNT_W = 8;

  // Least times round up to whole cycles, never below one.
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Cycle counts derived from the times above.
  localparam int PRECHARGE_CYC = ns_to_cycles(PRECHARGE_PERIOD_NS);
  localparam int ACTIVATE_CYC = ns_to_cycles(ACTIVATE_TO_ACCESS_NS);
  localparam int WRITE_RECOVERY_CYC = ns_to_cycles(WRITE_RECOVERY_NS);
  localparam int WRITE_TO_READ_CYC = ns_to_cycles(WRITE_TO_READ_NS);

  // Per-bank states; access periods of autoprecharge are their own states.
  typedef enum logic [2:0] {
    BANK_IDLE,
    BANK_ACTIVATING,
    BANK_ACTIVE,
    BANK_READ,
    BANK_WRITE,
    BANK_READ_AP,
    BANK_WRITE_AP,
    BANK_PRECHARGING
  } dbi_bank_state_t;

  // Decoded commands.
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACT,
    CMD_READ,
    CMD_WRITE,
    CMD_PRE,
    CMD_BST,
    CMD_REF,
    CMD_LMR
  } dbi_cmd_t;

  // Pin decode: chip select low, then row, column and write strobes.
  function automatic dbi_cmd_t decode_cmd(input logic csN, input logic rasN,
                                          input logic casN, input logic weN);
    dbi_cmd_t c;
    c = CMD_NOP;
    if (!csN)
    begin
      case ({rasN, casN, weN})
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h2: c = CMD_PRE;
        3'h6: c = CMD_BST;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_LMR;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction

  // Same-bank legality of a command for the bank's current state.
  function automatic logic cmd_allowed(input dbi_bank_state_t s,
                                       input dbi_cmd_t c);
    logic ok;
    ok = 1'b0;
    case (s)
      BANK_IDLE: ok = (c == CMD_ACT) || (c == CMD_PRE);
      BANK_ACTIVE: ok = (c == CMD_READ) || (c == CMD_WRITE) || (c == CMD_PRE);
      BANK_READ: ok = (c == CMD_READ) || (c == CMD_PRE) || (c == CMD_BST);
      BANK_WRITE: ok = (c == CMD_WRITE) || (c == CMD_PRE) || (c == CMD_BST);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

endpackage

`default_nettype wire

//--- rtl/dbi_bank_fsm.sv
/*
 * One bank's state machine with its down-counter.
 * Assumes the decoder only hands over commands already found legal.
 */
`default_nettype none

module dbi_bank_fsm #(
  parameter int BURST_LEN = dbi_pkg::BURST_LENGTH_SETTING
) (
  input wire logic clk_sys,
  input wire logic rst,
  dbi_bank_if.bank port
);

  localparam int W = dbi_pkg::CNT_W;
  // Read data occupies half the burst length in clock periods.
  localparam logic [W-1:0] RD_LEN = W'(BURST_LEN / 2);
  // Write data starts one cycle after the command.
  localparam logic [W-1:0] WR_LEN = W'(1 + BURST_LEN / 2);
  localparam logic [W-1:0] WR_REC = W'(dbi_pkg::WRITE_RECOVERY_CYC);
  localparam logic [W-1:0] T_RP = W'(dbi_pkg::PRECHARGE_CYC);
  localparam logic [W-1:0] T_RCD = W'(dbi_pkg::ACTIVATE_CYC);

  initial
  begin
    if (WR_LEN + WR_REC >= (1 << W) || T_RP >= (1 << W)
        || T_RCD >= (1 << W))
      $error("Bank timing does not fit the counter width.");
  end

  dbi_pkg::dbi_bank_state_t state_reg, state_next; // Current state.
  logic [W-1:0] cnt_reg, cnt_next; // Cycles left in a timed state.

  assign port.state = state_reg;

  // Next state: timed states leave when the counter reaches one.
  always_comb
  begin
    state_next = state_reg;
    cnt_next = (cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
    case (state_reg)
      dbi_pkg::BANK_IDLE:
      begin
        if (port.doAct)
        begin
          state_next = dbi_pkg::BANK_ACTIVATING;
          cnt_next = T_RCD;
        end
      end
      dbi_pkg::BANK_ACTIVATING:
      begin
        // Row active only once the activate time has run out.
        if (cnt_reg == W'(1))
          state_next = dbi_pkg::BANK_ACTIVE;
      end
      dbi_pkg::BANK_ACTIVE, dbi_pkg::BANK_READ, dbi_pkg::BANK_WRITE:
      begin
        if (port.doPre)
        begin
          state_next = dbi_pkg::BANK_PRECHARGING;
          cnt_next = T_RP;
        end
        else if (port.doBst)
        begin
          // Burst cut short; the row stays open.
          state_next = dbi_pkg::BANK_ACTIVE;
          cnt_next = '0;
        end
        else if (port.doRead)
        begin
          // Access period ends where the earliest precharge would go.
          state_next = port.autoPre ? dbi_pkg::BANK_READ_AP
                                    : dbi_pkg::BANK_READ;
          cnt_next = RD_LEN;
        end
        else if (port.doWrite)
        begin
          // With autoprecharge, the access period includes the write recovery time.
          state_next = port.autoPre ? dbi_pkg::BANK_WRITE_AP
                                    : dbi_pkg::BANK_WRITE;
          cnt_next = port.autoPre ? WR_LEN + WR_REC : WR_LEN;
        end
        else if (state_reg != dbi_pkg::BANK_ACTIVE && cnt_reg == W'(1))
          state_next = dbi_pkg::BANK_ACTIVE; // Burst ran to its end.
      end
      dbi_pkg::BANK_READ_AP, dbi_pkg::BANK_WRITE_AP:
      begin
        // Access period over: the precharge period follows.
        if (cnt_reg == W'(1))
        begin
          state_next = dbi_pkg::BANK_PRECHARGING;
          cnt_next = T_RP;
        end
      end
      dbi_pkg::BANK_PRECHARGING:
      begin
        if (cnt_reg == W'(1))
          state_next = dbi_pkg::BANK_IDLE;
      end
      default:
      begin
        state_next = dbi_pkg::BANK_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= dbi_pkg::BANK_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule // dbi_bank_fsm

`default_nettype wire

//--- rtl/dbi_interleave.sv
/*
 * Command decoder and cross-bank checker with one tracker per bank.
 * Assumes the command pins are synchronous to clk_sys and that exit
 * times from self refresh or power-down are kept by the controller.
 */
`default_nettype none

module dbi_interleave #(
  parameter int NUM_BANKS = 4,
  parameter int BURST_LEN = dbi_pkg::BURST_LENGTH_SETTING,
  parameter int LATENCY_X2 = dbi_pkg::READ_LATENCY_X2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [$clog2(NUM_BANKS)-1:0] bankSel,
  input wire logic autoPreSel,
  output logic [3*NUM_BANKS-1:0] bankStates,
  output logic cmdTaken,
  output logic cmdRefused,
  output logic allBanksIdle,
  output logic readBurstBusy,
  output logic writeBurstBusy
);

  localparam int W = dbi_pkg::CNT_W;
  localparam int BW = $clog2(NUM_BANKS);
  localparam int HALF_BL = BURST_LEN / 2;
  // Read latency rounded up to whole cycles.
  localparam int LAT_RU = (LATENCY_X2 + 1) / 2;
  // Gaps after an autoprecharge command to a command for another bank.
  localparam logic [W-1:0] GAP_WA_RD =
    W'(1 + HALF_BL + dbi_pkg::WRITE_TO_READ_CYC);
  localparam logic [W-1:0] GAP_WA_WR = W'(HALF_BL);
  localparam logic [W-1:0] GAP_RA_RD = W'(HALF_BL);
  localparam logic [W-1:0] GAP_RA_WR = W'(LAT_RU + HALF_BL);
  localparam logic [W-1:0] GAP_ROW = W'(1);

  initial
  begin
    if (!(BURST_LEN inside {2, 4, 8, 16}))
      $error("Burst length must be 2, 4, 8 or 16.");
    if (NUM_BANKS < 2 || (1 << BW) != NUM_BANKS)
      $error("Bank count must be a power of two of at least two.");
    if (LATENCY_X2 < 2 || GAP_WA_RD + 1 >= (1 << W))
      $error("Latency or gaps do not fit the counters.");
  end

  // Least spacing from the latest autoprecharge command to command c.
  function automatic logic [W-1:0] gap_needed(input logic wasWrite,
                                              input dbi_pkg::dbi_cmd_t c);
    logic [W-1:0] g;
    g = '0;
    case (c)
      dbi_pkg::CMD_READ: g = wasWrite ? GAP_WA_RD : GAP_RA_RD;
      dbi_pkg::CMD_WRITE: g = wasWrite ? GAP_WA_WR : GAP_RA_WR;
      dbi_pkg::CMD_ACT, dbi_pkg::CMD_PRE: g = GAP_ROW;
      default: g = '0;
    endcase
    return g;
  endfunction

  dbi_bank_if bankIf[NUM_BANKS] (); // One carrier per bank.
  dbi_pkg::dbi_bank_state_t stateArr [NUM_BANKS]; // Gathered states.
  logic [NUM_BANKS-1:0] actVec, rdVec, wrVec, preVec, bstVec; // Strobes.
  logic apFlag; // Autoprecharge bit for the issued read or write.

  // Trackers, one per bank.
  for (genvar g = 0; g < NUM_BANKS; g++)
  begin : gBank
    assign bankIf[g].doAct = actVec[g];
    assign bankIf[g].doRead = rdVec[g];
    assign bankIf[g].doWrite = wrVec[g];
    assign bankIf[g].doPre = preVec[g];
    assign bankIf[g].doBst = bstVec[g];
    assign bankIf[g].autoPre = apFlag;
    assign stateArr[g] = bankIf[g].state;
    assign bankStates[3*g +: 3] = bankIf[g].state;
    dbi_bank_fsm #(
      .BURST_LEN(BURST_LEN)
    ) uBank (
      .clk_sys(clk_sys),
      .rst(rst),
      .port(bankIf[g].bank)
    );
  end

  logic ckePrev_reg, ckePrev_next; // Clock enable of the previous cycle.
  logic [BW-1:0] burstBank_reg, burstBank_next; // Bank of latest burst.
  logic [BW-1:0] apBank_reg, apBank_next; // Bank of latest autoprecharge.
  logic apWrite_reg, apWrite_next; // That command was a write.
  logic [W-1:0] sinceAp_reg, sinceAp_next; // Cycles since it, saturating.
  logic taken_reg, taken_next; // Command executed last cycle.
  logic refused_reg, refused_next; // Command refused last cycle.
  logic idle_reg, idle_next; // All banks idle.
  logic rdBusy_reg, rdBusy_next; // Some bank is in a read burst.
  logic wrBusy_reg, wrBusy_next; // Some bank is in a write burst.

  assign cmdTaken = taken_reg;
  assign cmdRefused = refused_reg;
  assign allBanksIdle = idle_reg;
  assign readBurstBusy = rdBusy_reg;
  assign writeBurstBusy = wrBusy_reg;

  // Decode, check and route one command per cycle.  Refused commands
  // change no bank, so a misbehaving controller cannot corrupt state.
  always_comb
  begin
    dbi_pkg::dbi_cmd_t cmd;
    logic ckeValid;
    logic legal;
    logic anyIdle;
    logic anyRd;
    logic anyWr;
    logic preAllOk;
    logic [BW-1:0] target;
    cmd = dbi_pkg::decode_cmd(csN, rasN, casN, weN);
    ckeValid = ckePrev_reg && cke;
    anyIdle = 1'b1;
    anyRd = 1'b0;
    anyWr = 1'b0;
    preAllOk = 1'b1;
    for (int i = 0; i < NUM_BANKS; i++)
    begin
      anyIdle = anyIdle && (stateArr[i] == dbi_pkg::BANK_IDLE);
      anyRd = anyRd || (stateArr[i] == dbi_pkg::BANK_READ)
              || (stateArr[i] == dbi_pkg::BANK_READ_AP);
      anyWr = anyWr || (stateArr[i] == dbi_pkg::BANK_WRITE)
              || (stateArr[i] == dbi_pkg::BANK_WRITE_AP);
      preAllOk = preAllOk
                 && dbi_pkg::cmd_allowed(stateArr[i], dbi_pkg::CMD_PRE);
    end
    // Terminate goes to the latest burst's bank, not the addressed one.
    target = (cmd == dbi_pkg::CMD_BST) ? burstBank_reg
                                       : bankSel;
    legal = 1'b0;
    case (cmd)
      dbi_pkg::CMD_REF, dbi_pkg::CMD_LMR:
        legal = anyIdle;
      dbi_pkg::CMD_PRE:
        legal = autoPreSel ? preAllOk
                : dbi_pkg::cmd_allowed(stateArr[target], cmd);
      dbi_pkg::CMD_NOP:
        legal = 1'b0;
      default:
        legal = dbi_pkg::cmd_allowed(stateArr[target], cmd);
    endcase
    // A write may not cut into another bank's read, nor the reverse.
    if (cmd == dbi_pkg::CMD_WRITE && anyRd
        && stateArr[target] != dbi_pkg::BANK_READ)
      legal = 1'b0;
    if (cmd == dbi_pkg::CMD_READ && anyWr
        && stateArr[target] != dbi_pkg::BANK_WRITE)
      legal = 1'b0;
    // Other banks stay open during autoprecharge, after the least gap.
    if (target != apBank_reg && sinceAp_reg < gap_needed(apWrite_reg, cmd))
      legal = 1'b0;
    if (!ckeValid)
      legal = 1'b0;

    actVec = '0;
    rdVec = '0;
    wrVec = '0;
    preVec = '0;
    bstVec = '0;
    apFlag = autoPreSel;
    if (legal)
    begin
      case (cmd)
        dbi_pkg::CMD_ACT: actVec[target] = 1'b1;
        dbi_pkg::CMD_READ: rdVec[target] = 1'b1;
        dbi_pkg::CMD_WRITE: wrVec[target] = 1'b1;
        dbi_pkg::CMD_PRE:
        begin
          // Precharge all skips banks that are already idle.
          for (int i = 0; i < NUM_BANKS; i++)
            preVec[i] = (autoPreSel || BW'(i) == target)
                        && stateArr[i] != dbi_pkg::BANK_IDLE;
        end
        dbi_pkg::CMD_BST: bstVec[target] = 1'b1;
        default: actVec = '0;
      endcase
    end

    ckePrev_next = cke;
    burstBank_next = burstBank_reg;
    apBank_next = apBank_reg;
    apWrite_next = apWrite_reg;
    sinceAp_next = (sinceAp_reg == '1) ? sinceAp_reg
                                       : sinceAp_reg + W'(1);
    if (legal && (cmd == dbi_pkg::CMD_READ || cmd == dbi_pkg::CMD_WRITE))
    begin
      burstBank_next = target;
      if (autoPreSel)
      begin
        apBank_next = target;
        apWrite_next = (cmd == dbi_pkg::CMD_WRITE);
        sinceAp_next = W'(1);
      end
    end
    taken_next = legal;
    refused_next = ckeValid && cmd != dbi_pkg::CMD_NOP
                   && !legal;
    idle_next = anyIdle;
    rdBusy_next = anyRd;
    wrBusy_next = anyWr;
  end

  // Decoder registers.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ckePrev_reg <= 1'b0;
      burstBank_reg <= '0;
      apBank_reg <= '0;
      apWrite_reg <= 1'b0;
      sinceAp_reg <= '1;
      taken_reg <= 1'b0;
      refused_reg <= 1'b0;
      idle_reg <= 1'b1;
      rdBusy_reg <= 1'b0;
      wrBusy_reg <= 1'b0;
    end
    else
    begin
      ckePrev_reg <= ckePrev_next;
      burstBank_reg <= burstBank_next;
      apBank_reg <= apBank_next;
      apWrite_reg <= apWrite_next;
      sinceAp_reg <= sinceAp_next;
      taken_reg <= taken_next;
      refused_reg <= refused_next;
      idle_reg <= idle_next;
      rdBusy_reg <= rdBusy_next;
      wrBusy_reg <= wrBusy_next;
    end
  end

endmodule // dbi_interleave

`default_nettype wire

//--- test/dbi_ctrl_model.sv
/*
 * Memory controller stand-in that puts commands on the pins.
 * Assumes the bench asks for at most one command per cycle.
 */
`default_nettype none

module dbi_ctrl_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic reqValid,
  input wire dbi_pkg::dbi_cmd_t reqCmd,
  input wire logic [1:0] reqBank,
  input wire logic reqAp,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [1:0] bankSel,
  output logic autoPreSel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pad_reg; // Filler that flips every cycle on unused lines.
  logic pad_next;

  // Idle lines churn, so a stale command never reads as a live one.
  always_comb pad_next = ~pad_reg;
  always_ff @(posedge clk_sys) pad_reg <= rst ? 1'b0 : pad_next;

  // Pin encoding; with no request chip select stays high.
  always_comb
  begin
    {rasN, casN, weN} = {3{pad_reg}};
    bankSel = {2{pad_reg}};
    autoPreSel = pad_reg;
    csN = 1'b1;
    if (reqValid)
    begin
      csN = 1'b0;
      bankSel = reqBank;
      autoPreSel = reqAp;
      case (reqCmd)
        dbi_pkg::CMD_ACT: {rasN, casN, weN} = 3'h3;
        dbi_pkg::CMD_READ: {rasN, casN, weN} = 3'h5;
        dbi_pkg::CMD_WRITE: {rasN, casN, weN} = 3'h4;
        dbi_pkg::CMD_PRE: {rasN, casN, weN} = 3'h2;
        dbi_pkg::CMD_BST: {rasN, casN, weN} = 3'h6;
        dbi_pkg::CMD_REF: {rasN, casN, weN} = 3'h1;
        dbi_pkg::CMD_LMR: {rasN, casN, weN} = 3'h0;
        default: {rasN, casN, weN} = 3'h7;
      endcase
    end
  end
endmodule // dbi_ctrl_model

`default_nettype wire

//--- test/dbi_interleave_asserts.sv
/*
 * Checker for the bank interleave tracker, bound to its top module.
 * Assumes the default bank count, so bank 0 sits in bankStates[2:0].
 */
`default_nettype none

module dbi_interleave_asserts #(
  parameter int NUM_BANKS = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [$clog2(NUM_BANKS)-1:0] bankSel,
  input wire logic autoPreSel,
  input wire logic [3*NUM_BANKS-1:0] bankStates,
  input wire logic cmdTaken,
  input wire logic cmdRefused
);
  logic ckeSeen_reg; // Clock enable at the previous edge.
  logic ckeSeen_next; // Cleared by reset, as the design's copy is.
  logic ckeOk; // Both edges had clock enable high.
  logic [2:0] st0; // State of bank 0.

  // Track clock enable one edge back.
  always_comb ckeSeen_next = rst ? 1'b0 : cke;
  always_ff @(posedge clk_sys) ckeSeen_reg <= ckeSeen_next;
  assign ckeOk = ckeSeen_reg && cke;
  assign st0 = bankStates[2:0];

  // True when no other bank is busy, so no spacing rule can refuse.
  function automatic logic othersQuiet(input logic [3*NUM_BANKS-1:0] s);
    logic q;
    q = 1'b1;
    for (int i = 1; i < NUM_BANKS; i++)
    begin
      if (s[3*i+:3] != 3'h0 && s[3*i+:3] != 3'h2)
      begin
        q = 1'b0;
      end
    end
    return q;
  endfunction

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Building blocks of the quiet checks and the bank walks.
  sequence s_quiet;
    !cmdTaken && !cmdRefused;
  endsequence
  sequence s_activating;
    (st0 == 3'h1) [*2];
  endsequence
  sequence s_precharge;
    (st0 == 3'h7) [*2];
  endsequence

  property p_deselect;
    csN |=> s_quiet;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("pulse after a deselect cycle");
  property p_nop;
    !csN && rasN && casN && weN |=> s_quiet;
  endproperty
  a_nop: assert property (p_nop)
    else $error("pulse after a no operation cycle");
  property p_ckeLow;
    !cke |=> s_quiet;
  endproperty
  a_ckeLow: assert property (p_ckeLow)
    else $error("pulse while clock enable low");
  property p_idleRead;
    ckeOk && !csN && rasN && !casN && weN
      && bankStates[3*bankSel+:3] == 3'h0 |=> cmdRefused && !cmdTaken;
  endproperty
  a_idleRead: assert property (p_idleRead)
    else $error("read to an idle bank not refused");
  property p_refBusy;
    ckeOk && !csN && !rasN && !casN && weN && (|bankStates) |=> cmdRefused;
  endproperty
  a_refBusy: assert property (p_refBusy)
    else $error("refresh with a busy bank not refused");
  property p_actWalk;
    ckeOk && !csN && !rasN && casN && weN && bankSel == 0 && !(|bankStates)
      |=> cmdTaken ##0 s_activating ##1 st0 == 3'h2;
  endproperty
  a_actWalk: assert property (p_actWalk)
    else $error("activate walk wrong");
  property p_readAp;
    ckeOk && !csN && rasN && !casN && weN && autoPreSel && bankSel == 0
      && st0 == 3'h2 && othersQuiet(bankStates)
      |=> (st0 == 3'h5) [*2] ##1 s_precharge ##1 st0 == 3'h0;
  endproperty
  a_readAp: assert property (p_readAp)
    else $error("read with autoprecharge walk wrong");
  property p_writeAp;
    ckeOk && !csN && rasN && !casN && !weN && autoPreSel && bankSel == 0
      && st0 == 3'h2 && othersQuiet(bankStates)
      |=> (st0 == 3'h6) [*5] ##1 s_precharge ##1 st0 == 3'h0;
  endproperty
  a_writeAp: assert property (p_writeAp)
    else $error("write with autoprecharge walk wrong");
endmodule // dbi_interleave_asserts

bind dbi_interleave dbi_interleave_asserts #(.NUM_BANKS(NUM_BANKS)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .cke(cke),
  .csN(csN),
  .rasN(rasN),
  .casN(casN),
  .weN(weN),
  .bankSel(bankSel),
  .autoPreSel(autoPreSel),
  .bankStates(bankStates),
  .cmdTaken(cmdTaken),
  .cmdRefused(cmdRefused)
);

`default_nettype wire

//--- test/tb_dbi_interleave.sv
/*
 * Self-checking bench for the bank interleave tracker.
 * Assumes default parameters: four banks, burst of four, latency three.
 */
`default_nettype none

module tb_dbi_interleave;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys;
  logic rst;
  logic cke;
  logic reqValid; // Request handed to the controller model.
  dbi_pkg::dbi_cmd_t reqCmd;
  logic [1:0] reqBank;
  logic reqAp;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [1:0] bankSel;
  logic autoPreSel;
  logic [11:0] bankStates;
  logic cmdTaken;
  logic cmdRefused;
  logic allBanksIdle;
  logic readBurstBusy;
  logic writeBurstBusy;
  int miscompares;
  int totalChecks;

  dbi_ctrl_model ctrl (.clk_sys(clk_sys), .rst(rst), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqBank(reqBank), .reqAp(reqAp), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankSel(bankSel),
    .autoPreSel(autoPreSel));
  dbi_interleave dut (.clk_sys(clk_sys), .rst(rst), .cke(cke), .csN(csN),
    .rasN(rasN), .casN(casN), .weN(weN), .bankSel(bankSel),
    .autoPreSel(autoPreSel), .bankStates(bankStates), .cmdTaken(cmdTaken),
    .cmdRefused(cmdRefused), .allBanksIdle(allBanksIdle),
    .readBurstBusy(readBurstBusy), .writeBurstBusy(writeBurstBusy));

  // Free-running 100 MHz clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One cycle of pins; the design samples them at the following edge.
  task automatic step(input dbi_pkg::dbi_cmd_t c, input logic [1:0] b,
                      input logic ap, input logic v);
    @(posedge clk_sys);
    reqValid <= v;
    reqCmd <= c;
    reqBank <= b;
    reqAp <= ap;
  endtask

  task automatic idle(input int n);
    repeat (n) step(dbi_pkg::CMD_NOP, 2'h0, 1'b0, 1'b0);
  endtask

  // Answer to the command of the previous step, once the edge settles.
  task automatic pulse(input logic [1:0] exp);
    #1;
    chk({10'h000, cmdTaken, cmdRefused}, {10'h000, exp});
  endtask

  // Registered levels as one word: all idle, read busy, write busy.
  task automatic levels(input logic [2:0] exp);
    chk({9'h000, allBanksIdle, readBurstBusy, writeBurstBusy}, {9'h000, exp});
  endtask

  // Bounded wait until every bank is idle again.
  task automatic waitIdle();
    int n;
    n = 0;
    while (allBanksIdle !== 1'b1 && n < 40)
    begin
      idle(1);
      #1;
      n++;
    end
    if (n == 40)
    begin
      miscompares++;
      giveVerdict();
    end
  endtask

  task automatic t_reset();
    @(posedge clk_sys);
    #1;
    chk(bankStates, 12'h000);
    chk({9'h000, allBanksIdle, readBurstBusy, writeBurstBusy},
      12'h004);
  endtask

  // Clock enable gating, no operation and an illegal same-bank command.
  task automatic t_quiet();
    step(dbi_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1);
    cke <= 1'b0;
    step(dbi_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1);
    cke <= 1'b1;
    pulse(2'b00);
    step(dbi_pkg::CMD_NOP, 2'h0, 1'b0, 1'b1);
    pulse(2'b00);
    step(dbi_pkg::CMD_READ, 2'h0, 1'b0, 1'b1);
    pulse(2'b00);
    idle(1);
    pulse(2'b01);
    chk(bankStates, 12'h000);
  endtask

  // Read with autoprecharge on bank 0, other banks worked around it.
  task automatic t_readAp();
    step(dbi_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1);
    step(dbi_pkg::CMD_ACT, 2'h1, 1'b0, 1'b1);
    pulse(2'b10);
    idle(1);
    pulse(2'b10);
    idle(1);
    step(dbi_pkg::CMD_READ, 2'h0, 1'b1, 1'b1);
    // Let the edge's register updates settle before looking.
    #1;
    chk(bankStates, 12'h012);
    step(dbi_pkg::CMD_ACT, 2'h2, 1'b0, 1'b1);
    pulse(2'b10);
    step(dbi_pkg::CMD_WRITE, 2'h1, 1'b0, 1'b1);
    pulse(2'b10);
    step(dbi_pkg::CMD_READ, 2'h1, 1'b0, 1'b1);
    pulse(2'b01);
    step(dbi_pkg::CMD_BST, 2'h3, 1'b0, 1'b1);
    pulse(2'b10);
    step(dbi_pkg::CMD_WRITE, 2'h1, 1'b0, 1'b1);
    pulse(2'b10);
    chk(bankStates, 12'h090);
    levels(3'h2);
    step(dbi_pkg::CMD_REF, 2'h0, 1'b0, 1'b1);
    pulse(2'b10);
    // Read to bank 2 while the write burst of bank 1 is still running.
    step(dbi_pkg::CMD_READ, 2'h2, 1'b0, 1'b1);
    pulse(2'b01);
    idle(1);
    pulse(2'b01);
  endtask

  // Write with autoprecharge on bank 0, then refresh once all are idle.
  task automatic t_writeAp();
    step(dbi_pkg::CMD_ACT, 2'h0, 1'b0, 1'b1);
    idle(1);
    pulse(2'b10);
    idle(1);
    step(dbi_pkg::CMD_WRITE, 2'h0, 1'b1, 1'b1);
    step(dbi_pkg::CMD_WRITE, 2'h1, 1'b0, 1'b1);
    pulse(2'b10);
    step(dbi_pkg::CMD_WRITE, 2'h1, 1'b0, 1'b1);
    pulse(2'b01);
    levels(3'h1);
    idle(1);
    pulse(2'b10);
    // Precharge all must wait while bank 0 is in its access period.
    step(dbi_pkg::CMD_PRE, 2'h0, 1'b1, 1'b1);
    step(dbi_pkg::CMD_PRE, 2'h1, 1'b0, 1'b1);
    pulse(2'b01);
    step(dbi_pkg::CMD_PRE, 2'h2, 1'b0, 1'b1);
    pulse(2'b10);
    idle(1);
    pulse(2'b10);
    waitIdle();
    step(dbi_pkg::CMD_REF, 2'h0, 1'b0, 1'b1);
    step(dbi_pkg::CMD_LMR, 2'h0, 1'b0, 1'b1);
    pulse(2'b10);
    idle(1);
    pulse(2'b10);
    chk(bankStates, 12'h000);
  endtask

  task automatic giveVerdict();
    $display("checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset for six cycles with clock enable high, then the scenarios.
  initial
  begin
    miscompares = 0;
    totalChecks = 0;
    rst = 1'b1;
    cke = 1'b1;
    reqValid = 1'b0;
    reqCmd = dbi_pkg::CMD_NOP;
    reqBank = 2'h0;
    reqAp = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_quiet();
    t_readAp();
    t_writeAp();
    idle(2);
    giveVerdict();
  end
endmodule // tb_dbi_interleave

`default_nettype wire
